// *** design/bmrf_top.sv ***
`timescale 1ns/100ps
module bmrf_top
  import bmrf_pkg::*;
(
  input wire logic core_clk_in, // 20 MHz core clock
  input wire logic reset_in, // sync reset, active high
  input wire bmrf_pkg::bmrf_idx_t rd_a_idx_in, // read port a index
  input wire logic [1:0] rd_a_sel_in, // index 15 part select, port a
  input wire bmrf_pkg::bmrf_idx_t rd_b_idx_in, // read port b index
  input wire logic [1:0] rd_b_sel_in, // index 15 part select, port b
  input wire logic wr_en_in, // write strobe
  input wire bmrf_pkg::bmrf_idx_t wr_idx_in, // write index
  input wire logic [1:0] wr_sel_in, // index 15 part select, write
  input wire logic [bmrf_pkg::DATA_W-1:0] wr_data_in, // write data, whole word
  input wire logic branch_link_in, // branch with link pulse
  input wire logic pc_advance_in, // step pc by one word
  input wire logic exception_in, // exception entry pulse
  input wire bmrf_pkg::bmrf_mode_t exc_mode_in, // mode entered
  input wire logic [bmrf_pkg::ADDR_W-1:0] exc_addr_in, // vector byte address
  input wire logic force_translate_in, // single transfer with force bit
  input wire logic mem_xfer_in, // memory transfer request
  input wire logic mem_byte_in, // byte transfer when high
  input wire logic [bmrf_pkg::ADDR_W-1:0] mem_addr_in, // transfer byte address
  input wire logic [bmrf_pkg::DATA_W-1:0] store_data_in, // store value
  input wire logic [bmrf_pkg::DATA_W-1:0] mem_rdata_in, // memory read bus
  output logic [bmrf_pkg::DATA_W-1:0] rd_a_data_out, // port a data
  output logic [bmrf_pkg::DATA_W-1:0] rd_b_data_out, // port b data
  output logic [bmrf_pkg::ADDR_W-1:0] pc_out, // fetch byte address
  output bmrf_pkg::bmrf_mode_t mode_code_n_out, // inverted mode
  output logic address_translate_n_out, // translate, active low
  output logic [bmrf_pkg::ADDR_W-1:0] mem_addr_out, // memory byte address
  output logic [bmrf_pkg::DATA_W-1:0] mem_wdata_out, // memory write bus
  output logic [bmrf_pkg::LANES-1:0] mem_byte_en_out, // lane enables
  output logic [bmrf_pkg::DATA_W-1:0] load_data_out // aligned load value
);
  import bmrf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // map an index through the mode to its physical entry
  function automatic bmrf_phys_t phys_of(input bmrf_mode_t m, input bmrf_idx_t i);
    bmrf_phys_t p;
    p = {1'b0, i};
    case (m)
      MODE_FIQ: begin
        if (i >= FIQ_FIRST && i <= IDX_LINK) p = FIQ_BASE + {2'h0, i[2:0]};
      end
      MODE_IRQ: begin
        if (i >= BANK_FIRST && i <= IDX_LINK) p = IRQ_BASE + {4'h0, ~i[0]};
      end
      MODE_SVC: begin
        if (i >= BANK_FIRST && i <= IDX_LINK) p = SVC_BASE + {4'h0, ~i[0]};
      end
      default: p = {1'b0, i};
    endcase
    return p;
  endfunction : phys_of

  // masked view of index 15
  function automatic logic [DATA_W-1:0] r15_view(input logic [DATA_W-1:0] w, input logic [1:0] sel);
    logic [DATA_W-1:0] v;
    v = w;
    if (sel == R15_PC) v = w & PC_MASK;
    else if (sel == R15_PSR) v = w & PSR_MASK;
    return v;
  endfunction : r15_view

  ////////////////////////////////////////////////////////////////////////////
  // pc/status word state
  logic [PC_W-1:0] pc;
  logic [STAT_W-1:0] status_word;
  bmrf_mode_t mode;
  logic [PC_W-1:0] next_pc;
  logic [STAT_W-1:0] next_status_word;
  bmrf_mode_t next_mode;
  logic [DATA_W-1:0] pc_status_reg;
  logic mem_we;
  bmrf_phys_t mem_waddr;
  logic [DATA_W-1:0] mem_wdata;

  assign pc_status_reg = {status_word, pc, mode};

  // exception beats branch link beats a plain write on the single write port
  always_comb begin
    next_pc = pc;
    next_status_word = status_word;
    next_mode = mode;
    mem_we = 1'b0;
    mem_waddr = phys_of(mode, wr_idx_in);
    mem_wdata = wr_data_in;
    if (exception_in) begin
      mem_we = 1'b1;
      mem_waddr = phys_of(exc_mode_in, IDX_LINK);
      mem_wdata = pc_status_reg;
      next_pc = exc_addr_in[ADDR_W-1:2];
      next_mode = exc_mode_in;
      next_status_word[STAT_I] = 1'b1;
      if (exc_mode_in == MODE_FIQ) next_status_word[STAT_F] = 1'b1;
    end else begin
      if (branch_link_in) begin
        mem_we = 1'b1;
        mem_waddr = phys_of(mode, IDX_LINK);
        mem_wdata = pc_status_reg;
      end else if (wr_en_in && wr_idx_in != IDX_PC) begin
        mem_we = 1'b1;
      end
      if (wr_en_in && wr_idx_in == IDX_PC) begin
        if (wr_sel_in != R15_PSR) next_pc = wr_data_in[ADDR_W-1:2];
        if (wr_sel_in != R15_PC) begin
          next_status_word = wr_data_in[DATA_W-1:ADDR_W];
          next_mode = wr_data_in[MODE_W-1:0];
        end
      end else if (pc_advance_in) begin
        next_pc = pc + 24'h000001;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      pc <= PC_RESET;
      status_word <= STAT_RESET;
      mode <= MODE_RESET;
    end else begin
      pc <= next_pc;
      status_word <= next_status_word;
      mode <= next_mode;
    end
  end

  assign pc_out = {pc, 2'h0};

  ////////////////////////////////////////////////////////////////////////////
  // banked array; index 15 reads through the bypass so outputs stay registered
  bmrf_mem u_mem (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .we_in(mem_we),
    .waddr_in(mem_waddr),
    .wdata_in(mem_wdata),
    .ra_addr_in(phys_of(mode, rd_a_idx_in)),
    .ra_bypass_in(rd_a_idx_in == IDX_PC),
    .ra_bypass_data_in(r15_view(pc_status_reg, rd_a_sel_in)),
    .rb_addr_in(phys_of(mode, rd_b_idx_in)),
    .rb_bypass_in(rd_b_idx_in == IDX_PC),
    .rb_bypass_data_in(r15_view(pc_status_reg, rd_b_sel_in)),
    .ra_data_out(rd_a_data_out),
    .rb_data_out(rd_b_data_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode pins and memory lane steering
  bmrf_mode_t next_mode_code_n;
  logic next_translate_n;
  logic [ADDR_W-1:0] next_mem_addr;
  logic [DATA_W-1:0] next_mem_wdata;
  logic [LANES-1:0] next_byte_en;
  logic [DATA_W-1:0] next_load;
  logic xfer_byte;
  logic next_xfer_byte;

  always_comb begin
    next_mode_code_n = ~mode;
    next_translate_n = !((mode == MODE_USER) || (mode == MODE_SVC && force_translate_in));
    next_mem_addr = mem_addr_out;
    next_mem_wdata = mem_wdata_out;
    next_byte_en = mem_byte_en_out;
    next_xfer_byte = xfer_byte;
    if (mem_xfer_in) begin
      next_xfer_byte = mem_byte_in;
      if (mem_byte_in) begin
        next_mem_addr = mem_addr_in;
        next_mem_wdata = {LANES{store_data_in[7:0]}};
        next_byte_en = 4'(1 << mem_addr_in[1:0]);
      end else begin
        next_mem_addr = {mem_addr_in[ADDR_W-1:2], 2'h0};
        next_mem_wdata = store_data_in;
        next_byte_en = BE_WORD;
      end
    end
    // loads use the lane of the transfer now on the bus
    next_load = mem_rdata_in;
    if (xfer_byte) begin
      next_load = {24'h000000, mem_rdata_in[{mem_addr_out[1:0], 3'h0} +: 8]};
    end
  end

  // translate and mode follow the mode one cycle late, never glitch
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      mode_code_n_out <= ~MODE_RESET;
      address_translate_n_out <= 1'b1;
      mem_addr_out <= '0;
      mem_wdata_out <= '0;
      mem_byte_en_out <= '0;
      xfer_byte <= 1'b0;
      load_data_out <= '0;
    end else begin
      mode_code_n_out <= next_mode_code_n;
      address_translate_n_out <= next_translate_n;
      mem_addr_out <= next_mem_addr;
      mem_wdata_out <= next_mem_wdata;
      mem_byte_en_out <= next_byte_en;
      xfer_byte <= next_xfer_byte;
      load_data_out <= next_load;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_read15_a;
    rd_a_idx_in == IDX_PC && rd_a_sel_in == R15_PC;
  endsequence
  sequence s_word_store;
    mem_xfer_in && !mem_byte_in;
  endsequence

  // own disable term: the default one would switch this check off exactly while reset is high
  a_reset_mode_svc: assert property (@(posedge core_clk_in) disable iff (1'b0) reset_in |=>
    mode == MODE_SVC && mode_code_n_out == 2'h0) else $error("reset did not select supervisor");
  a_mode_pins_inv: assert property (!$past(reset_in) |-> mode_code_n_out == ~$past(mode))
    else $error("mode pins not inverse of mode");
  a_translate_low: assert property (!$past(reset_in) |-> address_translate_n_out ==
    !($past(mode) == MODE_USER || ($past(mode) == MODE_SVC && $past(force_translate_in))))
    else $error("translate output wrong");
  a_user_direct_map: assert property (mode == MODE_USER && wr_en_in && !exception_in
    && !branch_link_in && wr_idx_in != IDX_PC |-> mem_we && mem_waddr == {1'b0, wr_idx_in})
    else $error("user mode index banked");
  a_link_on_branch: assert property (branch_link_in && !exception_in |-> mem_we
    && mem_waddr == phys_of(mode, IDX_LINK) && mem_wdata == pc_status_reg)
    else $error("branch link did not save index 15");
  a_exc_bank_link: assert property (exception_in |-> mem_we && mem_waddr ==
    phys_of(exc_mode_in, IDX_LINK) && mem_wdata == pc_status_reg ##1 mode == $past(exc_mode_in))
    else $error("exception entry wrong");
  a_pc_word_step: assert property (pc_advance_in && !exception_in && !(wr_en_in && wr_idx_in == IDX_PC)
    |=> pc_out == $past(pc_out) + 26'h0000004) else $error("pc did not step one word");
  a_read15_pc_only: assert property (s_read15_a |=> rd_a_data_out == $past(pc_status_reg & PC_MASK))
    else $error("pc-only read wrong");
  a_store_lsb_first: assert property (s_word_store |=> mem_byte_en_out == BE_WORD
    && mem_wdata_out[7:0] == $past(store_data_in[7:0]) && mem_addr_out[1:0] == 2'h0)
    else $error("word store lanes wrong");
  a_byte_lane_sel: assert property (mem_xfer_in && mem_byte_in |=>
    mem_byte_en_out == 4'(1 << $past(mem_addr_in[1:0]))) else $error("byte lane wrong");
  a_fiq_bank_sel: assert property (mode == MODE_FIQ && wr_en_in && !exception_in && !branch_link_in
    && wr_idx_in >= FIQ_FIRST && wr_idx_in != IDX_PC |-> mem_waddr >= FIQ_BASE && mem_waddr < IRQ_BASE)
    else $error("fast bank not selected");
endmodule : bmrf_top

// *** design/bmrf_pkg.sv ***
package bmrf_pkg;
  // datapath widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 26;
  localparam int IDX_W = 4;
  localparam int PHYS_W = 5;
  localparam int PC_W = 24;
  localparam int STAT_W = 6;
  localparam int MODE_W = 2;
  localparam int LANES = 4;
  // 26 entries in the array plus the combined pc/status word held in flops
  localparam int MEM_DEPTH = 26;
  localparam int TOTAL_REGS = 27;

  typedef logic [MODE_W-1:0] bmrf_mode_t;
  typedef logic [IDX_W-1:0] bmrf_idx_t;
  typedef logic [PHYS_W-1:0] bmrf_phys_t;

  // internal mode encoding; the pins carry the inverse
  localparam bmrf_mode_t MODE_USER = 2'h0;
  localparam bmrf_mode_t MODE_FIQ = 2'h1;
  localparam bmrf_mode_t MODE_IRQ = 2'h2;
  localparam bmrf_mode_t MODE_SVC = 2'h3;

  // architectural indices
  localparam bmrf_idx_t IDX_LINK = 4'hE;
  localparam bmrf_idx_t IDX_PC = 4'hF;
  localparam bmrf_idx_t FIQ_FIRST = 4'h8;
  localparam bmrf_idx_t BANK_FIRST = 4'hD;

  // physical array layout: base 0..14, fast bank 15..21, irq 22..23, svc 24..25
  localparam bmrf_phys_t FIQ_BASE = 5'h0F;
  localparam bmrf_phys_t IRQ_BASE = 5'h16;
  localparam bmrf_phys_t SVC_BASE = 5'h18;

  // selection of pc and status parts of index 15
  localparam logic [1:0] R15_BOTH = 2'h0;
  localparam logic [1:0] R15_PC = 2'h1;
  localparam logic [1:0] R15_PSR = 2'h2;
  localparam logic [DATA_W-1:0] PC_MASK = 32'h03FFFFFC;
  localparam logic [DATA_W-1:0] PSR_MASK = 32'hFC000003;

  // status field positions within the upper six bits
  localparam int STAT_I = 1;
  localparam int STAT_F = 0;

  // reset values, then the all-lane enable of a word transfer
  localparam logic [PC_W-1:0] PC_RESET = 24'h000000;
  localparam logic [STAT_W-1:0] STAT_RESET = 6'h03;
  localparam bmrf_mode_t MODE_RESET = MODE_SVC;
  localparam logic [LANES-1:0] BE_WORD = 4'hF;
endpackage : bmrf_pkg

// *** design/bmrf_mem.sv ***
`timescale 1ns/100ps
module bmrf_mem
  import bmrf_pkg::*;
(
  input wire logic core_clk_in, // core clock
  input wire logic reset_in, // sync reset, clears read registers only
  input wire logic we_in, // write strobe
  input wire bmrf_pkg::bmrf_phys_t waddr_in, // write entry
  input wire logic [bmrf_pkg::DATA_W-1:0] wdata_in, // write data
  input wire bmrf_pkg::bmrf_phys_t ra_addr_in, // port a entry
  input wire logic ra_bypass_in, // port a takes bypass data
  input wire logic [bmrf_pkg::DATA_W-1:0] ra_bypass_data_in, // port a bypass value
  input wire bmrf_pkg::bmrf_phys_t rb_addr_in, // port b entry
  input wire logic rb_bypass_in, // port b takes bypass data
  input wire logic [bmrf_pkg::DATA_W-1:0] rb_bypass_data_in, // port b bypass value
  output logic [bmrf_pkg::DATA_W-1:0] ra_data_out, // port a registered data
  output logic [bmrf_pkg::DATA_W-1:0] rb_data_out // port b registered data
);
  import bmrf_pkg::*;

  logic [DATA_W-1:0] mem [MEM_DEPTH];
  logic [DATA_W-1:0] next_ra_data;
  logic [DATA_W-1:0] next_rb_data;

  ////////////////////////////////////////////////////////////////////////////
  // contents are not reset, software sets them up after start
  always_ff @(posedge core_clk_in) begin
    if (we_in && (int'(waddr_in) < MEM_DEPTH)) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read-before-write: a same-cycle write is seen one cycle later
  always_comb begin
    next_ra_data = '0;
    next_rb_data = '0;
    if (ra_bypass_in) begin
      next_ra_data = ra_bypass_data_in;
    end else if (int'(ra_addr_in) < MEM_DEPTH) begin
      next_ra_data = mem[ra_addr_in];
    end
    if (rb_bypass_in) begin
      next_rb_data = rb_bypass_data_in;
    end else if (int'(rb_addr_in) < MEM_DEPTH) begin
      next_rb_data = mem[rb_addr_in];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ra_data_out <= '0;
      rb_data_out <= '0;
    end else begin
      ra_data_out <= next_ra_data;
      rb_data_out <= next_rb_data;
    end
  end
endmodule : bmrf_mem

// *** testbench/bmrf_memory_model.sv ***
`timescale 1ns/100ps
// memory on the far side of the transfer port
module bmrf_memory_model
  import bmrf_pkg::*;
(
  input wire logic core_clk_in, // core clock
  input wire logic store_in, // commit the held transfer
  input wire logic [bmrf_pkg::ADDR_W-1:0] addr_in, // byte address
  input wire logic [bmrf_pkg::DATA_W-1:0] wdata_in, // write bus
  input wire logic [bmrf_pkg::LANES-1:0] be_in, // lane enables
  output logic [bmrf_pkg::DATA_W-1:0] rdata_out // read bus
);
  logic [DATA_W-1:0] mem [64];
  // lane l holds byte address 4n+l, so unwritten lanes stay unknown
  always @(posedge core_clk_in) begin
    for (int l = 0; l < LANES; l++) begin
      if (store_in && be_in[l]) begin
        mem[addr_in[7:2]][8*l +: 8] <= wdata_in[8*l +: 8];
      end
    end
  end
  // whole word returned; byte pick is the block's job
  assign rdata_out = mem[addr_in[7:2]];
endmodule : bmrf_memory_model

// *** testbench/banked_mode_register_file_test.sv ***
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module banked_mode_register_file_test;
  import bmrf_pkg::*;
  logic clk = 1'b0, rst = 1'b1, we = 1'b0, bl = 1'b0, adv = 1'b0, exc = 1'b0;
  logic ft = 1'b0, mx = 1'b0, mb = 1'b0, st = 1'b0;
  logic [1:0] rsa = 2'h0, rsb = 2'h0, ws = 2'h0;
  bmrf_mode_t em = 2'h0;
  bmrf_idx_t ra = 4'h0, rb = 4'h0, wi = 4'h0;
  logic [31:0] wd = 32'h0, sd = 32'h0, rdat, da, db, wdo, ld;
  logic [25:0] ea = 26'h0, ma = 26'h0, pc, mao;
  bmrf_mode_t mcn;
  logic trn;
  logic [3:0] be;
  int n_fail = 0, checks_done = 0, cyc = 0;

  bmrf_top i_dut (.core_clk_in(clk), .reset_in(rst), .rd_a_idx_in(ra), .rd_a_sel_in(rsa),
    .rd_b_idx_in(rb), .rd_b_sel_in(rsb), .wr_en_in(we), .wr_idx_in(wi), .wr_sel_in(ws),
    .wr_data_in(wd), .branch_link_in(bl), .pc_advance_in(adv), .exception_in(exc),
    .exc_mode_in(em), .exc_addr_in(ea), .force_translate_in(ft), .mem_xfer_in(mx),
    .mem_byte_in(mb), .mem_addr_in(ma), .store_data_in(sd), .mem_rdata_in(rdat),
    .rd_a_data_out(da), .rd_b_data_out(db), .pc_out(pc), .mode_code_n_out(mcn),
    .address_translate_n_out(trn), .mem_addr_out(mao), .mem_wdata_out(wdo),
    .mem_byte_en_out(be), .load_data_out(ld));
  bmrf_memory_model i_mem (.core_clk_in(clk), .store_in(st), .addr_in(mao), .wdata_in(wdo),
    .be_in(be), .rdata_out(rdat));

  //////////////////////////////////////////////////////////////////////////////
  always #25 clk = ~clk;
  // cut a hang short; the run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // one write cycle; strobe dropped at the taking edge
  task automatic wr(bmrf_idx_t i, logic [1:0] s, logic [31:0] d);
    @(posedge clk);
    we <= 1'b1; wi <= i; ws <= s; wd <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  // both ports read the same place, data one cycle after the index
  task automatic rd(bmrf_idx_t i, logic [1:0] s, logic [31:0] e);
    @(posedge clk);
    ra <= i; rsa <= s; rb <= i; rsb <= s;
    @(posedge clk);
    #1;
    `CHK(da, e)
    `CHK(db, e)
  endtask : rd
  // status write carries the mode in its low bits, flags cleared
  task automatic set_mode(bmrf_mode_t m);
    wr(IDX_PC, R15_PSR, {30'h0, m});
  endtask : set_mode

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    `CHK(mcn, ~MODE_SVC)
    `CHK(trn, 1'b1)
    `CHK(pc, 26'h0)
    $display("test reset done");
  endtask : t_reset
  // every mode with and without the force bit
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      for (int f = 0; f < 2; f++) begin
        set_mode(m[1:0]);
        @(posedge clk);
        ft <= f[0];
        tick(2);
        #1;
        `CHK(mcn, ~m[1:0])
        `CHK(trn, (m == 0 || (m == 3 && f == 1)) ? 1'b0 : 1'b1)
      end
    end
    ft <= 1'b0;
    $display("test modes done");
  endtask : t_modes
  task automatic t_bank;
    set_mode(MODE_USER);
    wr(4'h8, 2'h0, 32'hBA5E_0008);
    wr(4'hD, 2'h0, 32'hC0C0_0013);
    set_mode(MODE_SVC);
    wr(4'hD, 2'h0, 32'h5C5C_0013);
    set_mode(MODE_FIQ);
    wr(4'h8, 2'h0, 32'hF1F1_0008);
    set_mode(MODE_IRQ);
    rd(4'h8, 2'h0, 32'hBA5E_0008);
    set_mode(MODE_USER);
    rd(4'h8, 2'h0, 32'hBA5E_0008);
    rd(4'hD, 2'h0, 32'hC0C0_0013);
    set_mode(MODE_SVC);
    rd(4'hD, 2'h0, 32'h5C5C_0013);
    set_mode(MODE_FIQ);
    rd(4'h8, 2'h0, 32'hF1F1_0008);
    $display("test banking done");
  endtask : t_bank
  // link copy, pc step, exception entry with its own link register
  task automatic t_link;
    set_mode(MODE_USER);
    wr(IDX_PC, R15_PC, 32'h0000_1235);
    tick(2);
    #1;
    `CHK(pc, 26'h1234)
    @(posedge clk) bl <= 1'b1;
    @(posedge clk) bl <= 1'b0;
    rd(IDX_LINK, 2'h0, 32'h0000_1234);
    @(posedge clk) adv <= 1'b1;
    @(posedge clk) adv <= 1'b0;
    tick(2);
    #1;
    `CHK(pc, 26'h1238)
    @(posedge clk);
    exc <= 1'b1; em <= MODE_IRQ; ea <= 26'h18;
    @(posedge clk) exc <= 1'b0;
    tick(2);
    #1;
    `CHK(mcn, ~MODE_IRQ)
    `CHK(pc, 26'h18)
    rd(IDX_LINK, 2'h0, 32'h0000_1238);
    rd(IDX_PC, R15_BOTH, 32'h0800_001A);
    rd(IDX_PC, R15_PC, 32'h0000_0018);
    rd(IDX_PC, R15_PSR, 32'h0800_0002);
    // branch with link inside the handler lands in the handler's own link register
    @(posedge clk) bl <= 1'b1;
    @(posedge clk) bl <= 1'b0;
    rd(IDX_LINK, 2'h0, 32'h0800_001A);
    set_mode(MODE_USER);
    rd(IDX_LINK, 2'h0, 32'h0000_1234);
    // fast entry sets both flags and banks its own link register
    @(posedge clk);
    exc <= 1'b1; em <= MODE_FIQ; ea <= 26'h1C;
    @(posedge clk) exc <= 1'b0;
    tick(2);
    #1;
    `CHK(mcn, ~MODE_FIQ)
    rd(IDX_LINK, 2'h0, 32'h0000_0018);
    rd(IDX_PC, R15_PSR, 32'h0C00_0001);
    rd(4'h8, 2'h0, 32'hF1F1_0008);
    $display("test link done");
  endtask : t_link
  // word store, byte load back, byte store lanes
  task automatic t_mem;
    @(posedge clk);
    mx <= 1'b1; mb <= 1'b0; ma <= 26'h101; sd <= 32'h4433_2211;
    @(posedge clk);
    mx <= 1'b0; st <= 1'b1;
    @(posedge clk);
    st <= 1'b0;
    #1;
    `CHK(mao, 26'h100)
    `CHK(be, 4'hF)
    `CHK(wdo, 32'h4433_2211)
    @(posedge clk);
    mx <= 1'b1; mb <= 1'b1; ma <= 26'h102;
    @(posedge clk) mx <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(be, 4'h4)
    `CHK(ld, 32'h0000_0033)
    @(posedge clk);
    mx <= 1'b1; ma <= 26'h103; sd <= 32'h0000_00AB;
    @(posedge clk) mx <= 1'b0;
    #1;
    `CHK(wdo, 32'hABAB_ABAB)
    `CHK(be, 4'h8)
    $display("test memory done");
  endtask : t_mem

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(10);
    rst <= 1'b0;
    tick(1);
    #1;
    t_reset();
    t_modes();
    t_bank();
    t_link();
    t_mem();
    give_verdict();
  end
endmodule : banked_mode_register_file_test
